// [src/power_mgmt_pkg.sv]
// Purpose: Constants shared by the power management register bank.
// Assumes: 32-bit AXI4-Lite register access, byte offsets as printed.
// Notes:   Upper capability aux current and wake support fields are writable-sticky; see main file.
package power_mgmt_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFFS_POWER_CAPABILITIES = 8'hc0;
    localparam logic [7:0] OFFS_POWER_CTRL_STATUS  = 8'hc4;
    localparam logic [7:0] OFFS_LOCK_CTRL          = 8'hc8;
    localparam logic [7:0] OFFS_PORT_CFG           = 8'hcc;

    // ----------------------------------------------------------------
    // Fixed capability fields: lower half ID and next pointer, plus version in bits 18:16
    // ----------------------------------------------------------------
    localparam logic [7:0] CAP_ID_VALUE            = 8'h01;
    localparam logic [7:0] CAP_NEXT_VALUE          = 8'hd0;
    localparam logic [2:0] CAP_VERSION_VALUE       = 3'h3;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int AUX_LSB        = 22;
    localparam int AUX_MSB        = 24;
    localparam int D1_BIT         = 25;
    localparam int D2_BIT         = 26;
    localparam int WAKE_SUP_LSB   = 27;
    localparam int WAKE_SUP_MSB   = 31;
    localparam int POWER_STATE_SEL_LSB     = 0;
    localparam int POWER_STATE_SEL_MSB     = 1;
    localparam int NOSOFT_BIT     = 3;
    localparam int WAKE_EN_BIT    = 8;
    localparam int WAKE_STS_BIT   = 15;
    localparam int BUS_STATE_BIT  = 22;
    localparam int BUS_PCC_BIT    = 23;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] AUX_RESET       = 3'h7;
    localparam logic [4:0] WAKE_SUP_RESET  = 5'h19;
    localparam logic       NOSOFT_RESET    = 1'h1;

    // ----------------------------------------------------------------
    // Power states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_D0     = 2'b00,
        PS_D1     = 2'b01,
        PS_D2     = 2'b10,
        PS_D3HOT  = 2'b11
    } power_state_type;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage : power_mgmt_pkg

// [src/wake_status_flag.sv]
// Purpose: Sticky wake status flag, set by local events, cleared by write one.
// Assumes: Event and clear are on the core clock.
// Notes:   Of the resets, only a fundamental reset clears the flag.
`timescale 1ns/10ps
module wake_status_flag (
    // Clock and fundamental reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    // Events
    input  wire logic i_set,
    input  wire logic i_clear,
    // State
    output logic      o_flag
);

    // Set wins over a clear in the same cycle so no event is lost.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clear) begin
            o_flag <= 1'b0;
        end
    end

    flag_set_wins_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        i_set |=> o_flag) else $error("wake status lost an event");

endmodule : wake_status_flag

// [src/power_mgmt_capability_regs.sv]
// Purpose: Per-port power management capability and control/status registers.
// Assumes: AXI4-Lite slave on i_clock; i_hot_rst is a synchronous pulse.
// Notes:   Sticky and enable bits survive hot reset, only i_rst_b clears them.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/10ps
module power_mgmt_capability_regs
    import power_mgmt_pkg::*;
(
    // Clock and resets
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_hot_rst,
    // Port events
    input  wire logic        i_local_wake,
    input  wire logic        i_fwd_wake,
    // AXI4-Lite write address and data
    input  wire logic        i_awvalid,
    input  wire logic [7:0]  i_awaddr,
    output logic             o_awready,
    input  wire logic        i_wvalid,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    output logic             o_wready,
    // AXI4-Lite write response
    output logic             o_bvalid,
    output logic [1:0]       o_bresp,
    input  wire logic        i_bready,
    // AXI4-Lite read
    input  wire logic        i_arvalid,
    input  wire logic [7:0]  i_araddr,
    output logic             o_arready,
    output logic             o_rvalid,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    input  wire logic        i_rready,
    // Power state and wake message outputs
    output logic [1:0]       o_power_state,
    output logic             o_wake_msg_send
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [2:0]      aux_current_req;
    logic [4:0]      wake_support;
    power_state_type power_state_sel;
    logic            context_preserved;
    logic            wake_msg_enable;
    logic            wake_status;
    logic            cfg_lock;
    logic            upstream_port;
    logic            aw_held;
    logic            w_held;
    logic [7:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;

    // ----------------------------------------------------------------
    // Write channel capture
    // ----------------------------------------------------------------
    wire aw_take  = i_awvalid && o_awready;
    wire w_take   = i_wvalid && o_wready;
    wire do_write = aw_held && w_held && !o_bvalid;
    wire hit_cap  = (aw_addr == OFFS_POWER_CAPABILITIES);
    wire hit_csr  = (aw_addr == OFFS_POWER_CTRL_STATUS);
    wire hit_lock = (aw_addr == OFFS_LOCK_CTRL);
    wire hit_port = (aw_addr == OFFS_PORT_CFG);
    wire wr_map   = hit_cap || hit_csr || hit_lock || hit_port;
    wire wr_cap   = do_write && hit_cap && !cfg_lock;
    wire wr_csr   = do_write && hit_csr;
    wire wr_cfg   = do_write && hit_port && !cfg_lock;
    wire wr_lockr = do_write && hit_lock;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
        end else begin
            o_awready <= !(aw_held || aw_take) || do_write;
            o_wready  <= !(w_held || w_take) || do_write;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_bvalid <= 1'b0;
            o_bresp  <= AXI_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp  <= wr_map ? AXI_OKAY : AXI_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Capability upper half
    // ----------------------------------------------------------------
    // sticky writable fields
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            aux_current_req <= AUX_RESET;
            wake_support    <= WAKE_SUP_RESET;
        end else if (wr_cap && w_strb[3]) begin
            aux_current_req <= w_data[AUX_MSB:AUX_LSB];
            wake_support    <= w_data[WAKE_SUP_MSB:WAKE_SUP_LSB];
        end else if (wr_cap && w_strb[2]) begin
            aux_current_req[1:0] <= w_data[AUX_LSB+1:AUX_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Lock and port configuration
    // ----------------------------------------------------------------
    // The lock only ever sets, so a loader can seal the set-up until reset.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_lock      <= 1'b0;
            upstream_port <= 1'b0;
        end else begin
            if (wr_lockr && w_strb[0] && w_data[0]) begin
                cfg_lock <= 1'b1;
            end
            if (wr_cfg && w_strb[0]) begin
                upstream_port <= w_data[0];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            context_preserved <= NOSOFT_RESET;
        end else if (wr_cfg && w_strb[0]) begin
            context_preserved <= w_data[1];
        end
    end

    // ----------------------------------------------------------------
    // Control and status
    // ----------------------------------------------------------------
    wire [1:0] wr_state  = w_data[POWER_STATE_SEL_MSB:POWER_STATE_SEL_LSB];
    wire state_legal     = (wr_state == PS_D0) || (wr_state == PS_D3HOT);
    wire state_write     = wr_csr && w_strb[0] && state_legal;

    // power state select, hot reset returns it to D0
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            power_state_sel <= PS_D0;
        end else if (i_hot_rst) begin
            power_state_sel <= PS_D0;
        end else if (state_write) begin
            power_state_sel <= power_state_type'(wr_state);
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wake_msg_enable <= 1'b0;
        end else if (wr_csr && w_strb[1]) begin
            wake_msg_enable <= w_data[WAKE_EN_BIT];
        end
    end

    wire wake_set   = i_local_wake && !upstream_port;
    wire wake_clear = wr_csr && w_strb[1] && w_data[WAKE_STS_BIT];

    wake_status_flag status_flag (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_set   (wake_set),
        .i_clear (wake_clear),
        .o_flag  (wake_status)
    );

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wake_msg_send <= 1'b0;
            o_power_state   <= 2'h0;
        end else begin
            o_wake_msg_send <= wake_set && wake_msg_enable;
            o_power_state   <= power_state_sel;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // constant zero fields
    wire [31:0] cap_word = {wake_support, 1'b0, 1'b0, aux_current_req,
                            1'b0, 1'b0, 1'b0, CAP_VERSION_VALUE,
                            CAP_NEXT_VALUE, CAP_ID_VALUE};
    wire [31:0] csr_word = {8'h00, 1'b0, 1'b0, 6'h00, wake_status, 2'h0, 4'h0,
                            wake_msg_enable, 4'h0, context_preserved, 1'b0,
                            power_state_sel};
    wire        rd_cap   = (i_araddr == OFFS_POWER_CAPABILITIES);
    wire        rd_csr   = (i_araddr == OFFS_POWER_CTRL_STATUS);
    wire        rd_lock  = (i_araddr == OFFS_LOCK_CTRL);
    wire        rd_port  = (i_araddr == OFFS_PORT_CFG);
    wire        rd_map   = rd_cap || rd_csr || rd_lock || rd_port;
    wire [31:0] rd_word  = rd_cap  ? cap_word :
                           rd_csr  ? csr_word :
                           rd_lock ? {31'h0, cfg_lock} :
                           rd_port ? {30'h0, context_preserved, upstream_port} :
                           32'h0000_0000;
    wire        ar_take  = i_arvalid && o_arready;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= AXI_OKAY;
        end else if (ar_take) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_word;
            o_rresp   <= rd_map ? AXI_OKAY : AXI_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence reserved_write_s;
        wr_csr && w_strb[0] && (wr_state == PS_D1 || wr_state == PS_D2) && !i_hot_rst;
    endsequence

    reserved_state_kept_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        reserved_write_s |=> $stable(power_state_sel))
        else $error("reserved power state accepted");

    state_legal_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        power_state_sel == PS_D0 || power_state_sel == PS_D3HOT)
        else $error("power state holds a reserved code");

    state_write_taken_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        state_write && !i_hot_rst |=> power_state_sel == $past(wr_state) ##1
        o_power_state == $past(wr_state, 2))
        else $error("power state write not applied");

    hot_keeps_enable_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        i_hot_rst && !wr_csr |=> $stable(wake_msg_enable))
        else $error("hot reset changed wake enable");

    wake_gated_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_wake_msg_send |-> $past(wake_msg_enable) && $past(i_local_wake))
        else $error("wake message sent while disabled");

    upstream_never_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        upstream_port && !wake_status |=> !wake_status)
        else $error("upstream port set wake status");

    forward_no_status_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        i_fwd_wake && !i_local_wake && !wake_status |=> !wake_status)
        else $error("forwarded wake set status");

    status_clears_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        wake_clear && !wake_set |=> !wake_status)
        else $error("write one did not clear wake status");

    zero_fields_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_rvalid |-> (($past(rd_csr) && o_rdata[31:22] == 10'h0 && o_rdata[14:9] == 6'h0)
        || !$past(rd_csr) || !$past(ar_take)))
        else $error("unimplemented field read nonzero");

endmodule : power_mgmt_capability_regs

// [tb/test_power_mgmt_capability_regs.sv]
// Purpose: Self-checking bench for the power management register bank.
// Assumes: AXI4-Lite slave that answers one write and one read at a time.
// Notes:   Expected register images come from a small shadow model below.
`timescale 1ns/10ps
module test_power_mgmt_capability_regs
    import power_mgmt_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic        i_clock = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_hot_rst = 1'b0;
    logic        i_local_wake = 1'b0;
    logic        i_fwd_wake = 1'b0;
    logic        i_awvalid = 1'b0;
    logic [7:0]  i_awaddr = 8'h00;
    logic        i_wvalid = 1'b0;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0]  i_wstrb = 4'h0;
    logic        i_bready = 1'b0;
    logic        i_arvalid = 1'b0;
    logic [7:0]  i_araddr = 8'h00;
    logic        i_rready = 1'b0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wake_msg_send;
    logic [1:0]  o_bresp, o_rresp, o_power_state;
    logic [31:0] o_rdata;
    // Shadow model and bookkeeping.
    logic [1:0]  exp_ps;
    logic        exp_en, exp_sts, upstream;
    logic [2:0]  exp_aux;
    logic [4:0]  exp_sup;
    logic [31:0] rd, d;
    logic [1:0]  rr;
    logic        sent;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    always #12.5 i_clock = ~i_clock;

    power_mgmt_capability_regs u_dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_hot_rst(i_hot_rst),
        .i_local_wake(i_local_wake), .i_fwd_wake(i_fwd_wake),
        .i_awvalid(i_awvalid), .i_awaddr(i_awaddr), .o_awready(o_awready),
        .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_wready(o_wready),
        .o_bvalid(o_bvalid), .o_bresp(o_bresp), .i_bready(i_bready),
        .i_arvalid(i_arvalid), .i_araddr(i_araddr), .o_arready(o_arready),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp), .i_rready(i_rready),
        .o_power_state(o_power_state), .o_wake_msg_send(o_wake_msg_send)
    );

    // ----------------------------------------------------------------
    // Expectations and reporting
    // ----------------------------------------------------------------
    function automatic logic [31:0] cap_exp();
        return {exp_sup, 2'b00, exp_aux, 3'b000, CAP_VERSION_VALUE, CAP_NEXT_VALUE,
                CAP_ID_VALUE};
    endfunction : cap_exp

    function automatic logic [31:0] csr_exp();
        return {16'h0, exp_sts, 6'h0, exp_en, 4'h0, NOSOFT_RESET, 1'b0, exp_ps};
    endfunction : csr_exp

    task automatic stop_test();
        if (failures == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // A hang anywhere ends in the same closing report.
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= v;
        i_wstrb <= s;
        i_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge i_clock);
            if (!aw_done && o_awready === 1'b1) begin
                aw_done = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (!w_done && o_wready === 1'b1) begin
                w_done = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
        @(posedge i_clock);
        while (o_bvalid !== 1'b1) @(posedge i_clock);
        rr = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_clock);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        @(posedge i_clock);
        while (o_arready !== 1'b1) @(posedge i_clock);
        i_arvalid <= 1'b0;
        @(posedge i_clock);
        while (o_rvalid !== 1'b1) @(posedge i_clock);
        rd = o_rdata;
        rr = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_clock);
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        axi_write(a, v, 4'hf);
        check({30'h0, rr}, {30'h0, AXI_OKAY});
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        axi_read(a);
        check(rd, want);
        check({30'h0, rr}, {30'h0, AXI_OKAY});
    endtask : rd_chk

    // One-cycle event pulse; the send output is taken one cycle later.
    task automatic pulse(input logic loc, input logic fwd);
        i_local_wake <= loc;
        i_fwd_wake <= fwd;
        @(posedge i_clock);
        i_local_wake <= 1'b0;
        i_fwd_wake <= 1'b0;
        @(posedge i_clock);
        sent = o_wake_msg_send;
    endtask : pulse

    task automatic full_reset();
        i_rst_b <= 1'b0;
        repeat (6) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        {exp_ps, exp_en, exp_sts, upstream} = '0;
        exp_aux = AUX_RESET;
        exp_sup = WAKE_SUP_RESET;
    endtask : full_reset

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(86));
        full_reset();
        rd_chk(OFFS_POWER_CAPABILITIES, cap_exp());
        rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
        // every state code, read-only fields written with ones
        for (int i = 0; i < 10; i++) begin
            d = (i == 9) ? 32'hffff_7fff : $urandom;
            d[1:0] = (i < 4) ? i[1:0] : d[1:0];
            d[15] = 1'b0;
            if (d[1:0] == 2'b00 || d[1:0] == 2'b11) exp_ps = d[1:0];
            exp_en = d[8];
            wr(OFFS_POWER_CTRL_STATUS, d);
            rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
            check({30'h0, o_power_state}, {30'h0, exp_ps});
        end
        // local and forwarded events, enable off then on
        for (int e = 0; e < 2; e++) begin
            exp_en = e[0];
            wr(OFFS_POWER_CTRL_STATUS, {23'h0, exp_en, 6'h0, exp_ps});
            pulse(1'b0, 1'b1);
            check({31'h0, sent}, 32'h0);
            rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
            pulse(1'b1, 1'b0);
            exp_sts = 1'b1;
            check({31'h0, sent}, {31'h0, exp_en});
            rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
            wr(OFFS_POWER_CTRL_STATUS, {16'h0, 1'b1, 6'h0, exp_en, 6'h0, exp_ps});
            exp_sts = 1'b0;
            rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
        end
        // hot reset keeps enable, sends state back to D0
        wr(OFFS_POWER_CTRL_STATUS, 32'h0000_0103);
        exp_ps = PS_D3HOT;
        i_hot_rst <= 1'b1;
        @(posedge i_clock);
        i_hot_rst <= 1'b0;
        @(posedge i_clock);
        exp_ps = PS_D0;
        rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
        check({30'h0, o_power_state}, {30'h0, exp_ps});
        // an upstream port never flags or sends
        wr(OFFS_PORT_CFG, 32'h0000_0003);
        pulse(1'b1, 1'b0);
        check({31'h0, sent}, 32'h0);
        rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
        wr(OFFS_PORT_CFG, 32'h0000_0002);
        // sticky capability fields survive hot reset
        d = $urandom;
        wr(OFFS_POWER_CAPABILITIES, d);
        exp_aux = d[24:22];
        exp_sup = d[31:27];
        rd_chk(OFFS_POWER_CAPABILITIES, cap_exp());
        i_hot_rst <= 1'b1;
        @(posedge i_clock);
        i_hot_rst <= 1'b0;
        rd_chk(OFFS_POWER_CAPABILITIES, cap_exp());
        // Unmapped place answers with an error and zero data.
        axi_read(8'hd0);
        check(rd, 32'h0);
        check({30'h0, rr}, {30'h0, AXI_SLVERR});
        axi_write(8'hd0, 32'hffff_ffff, 4'hf);
        check({30'h0, rr}, {30'h0, AXI_SLVERR});
        // once locked, the loader's set-up can no longer be changed
        wr(OFFS_LOCK_CTRL, 32'h0000_0001);
        rd_chk(OFFS_LOCK_CTRL, 32'h0000_0001);
        wr(OFFS_PORT_CFG, 32'h0000_0000);
        rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
        wr(OFFS_POWER_CAPABILITIES, ~cap_exp());
        rd_chk(OFFS_POWER_CAPABILITIES, cap_exp());
        full_reset();
        rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
        rd_chk(OFFS_POWER_CAPABILITIES, cap_exp());
        // a loader arms wake enable after reset, and local events then send
        wr(OFFS_POWER_CTRL_STATUS, 32'h0000_0100);
        exp_en = 1'b1;
        rd_chk(OFFS_POWER_CTRL_STATUS, csr_exp());
        pulse(1'b1, 1'b0);
        check({31'h0, sent}, 32'h0000_0001);
        stop_test();
    end
endmodule : test_power_mgmt_capability_regs
